// file: src/sgfc_pkg.sv
package sgfc_pkg;
  // Register offsets
  localparam logic [7:0] SGFC_OFS_LIMITS = 8'h04;
  localparam logic [7:0] SGFC_OFS_FEATURES = 8'h05;
  // Field positions, frame limits register
  localparam int SGFC_BIT_UCAST_VLAN_DISCARD = 7;
  localparam int SGFC_BIT_MCAST_STORM_OFF = 6;
  localparam int SGFC_BIT_BACKPRESSURE_MODE = 5;
  localparam int SGFC_BIT_FAIR_MODE = 4;
  localparam int SGFC_BIT_NO_COLL_DROP = 3;
  localparam int SGFC_BIT_HUGE = 2;
  localparam int SGFC_BIT_SIZE_CHECK_OFF = 1;
  localparam int SGFC_BIT_PRIO_RESERVE = 0;
  // Field positions, forwarding features register
  localparam int SGFC_BIT_TAG_VLAN = 7;
  localparam int SGFC_BIT_IGMP_SNOOP = 6;
  localparam int SGFC_BIT_DIRECT = 5;
  localparam int SGFC_BIT_PRETAG = 4;
  localparam int SGFC_BIT_SCHED_HI = 3;
  localparam int SGFC_BIT_SCHED_LO = 2;
  localparam int SGFC_BIT_TAG_MASK = 1;
  localparam int SGFC_BIT_SNIFF_AND = 0;
  // Reset values; bits 3 and 1 of limits are overlaid from straps
  localparam logic [7:0] SGFC_RST_LIMITS = 8'hF0;
  localparam logic [7:0] SGFC_RST_FEATURES = 8'h00;
  // Frame length limits in bytes
  localparam logic [10:0] SGFC_LEN_UNTAGGED = 11'h5EE;
  localparam logic [10:0] SGFC_LEN_TAGGED = 11'h5F2;
  localparam logic [10:0] SGFC_LEN_LEGACY = 11'h600;
  localparam logic [10:0] SGFC_LEN_HUGE = 11'h77C;
  // Reserved high-priority buffers per output queue
  localparam logic [6:0] SGFC_PRIO_BUFFERS = 7'h30;
  // Scheduling ratios high:low, zero means strict priority
  localparam logic [3:0] SGFC_RATIO_STRICT = 4'h0;
  localparam logic [3:0] SGFC_RATIO_10 = 4'hA;
  localparam logic [3:0] SGFC_RATIO_5 = 4'h5;
  localparam logic [3:0] SGFC_RATIO_2 = 4'h2;
endpackage

// file: src/sgfc_switch_global_forwarding_control.sv
`timescale 1ns/1ps
// How it works
// - Check disabled: accept up to 1536 bytes
// - Else 1522 tagged, 1518 untagged limits
// - Reserve bit gives 48 high-priority buffers
// - Tag VLAN bit turns 802.1q mode
// - Snooping sends IGMP frames to MII
// - Direct mode forwards by preamble, no lookup
// - Pre-tag puts source port in preamble
// - Scheme field: strict, 10/1, 5/1, 2/1
// - Tag mask uses low 5 VID bits
// - Sniff set: source and destination match
// - Sniff clear: source or destination matches
// - Huge bit allows 1916, overrides check
module sgfc_switch_global_forwarding_control
  import sgfc_pkg::*;
#(
  parameter int RESERVE_BUFFERS = int'(SGFC_PRIO_BUFFERS)
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic size_limit_strap_pin,
  input wire logic collision_strap_pin,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_write_data,
  input wire logic reg_read,
  output logic [7:0] reg_read_data,
  output logic reg_read_valid,
  output logic [10:0] max_len_tagged,
  output logic [10:0] max_len_untagged,
  output logic cpu_special_tag_id_exempt_from_tag_limit,
  output logic [6:0] reserved_hi_buffers,
  output logic tag_vlan_enable,
  output logic igmp_to_mii_enable,
  output logic mii_direct_enable,
  output logic mii_pretag_enable,
  output logic sched_strict,
  output logic [3:0] sched_ratio,
  output logic vid_port_mask_enable,
  output logic sniff_match_both,
  output logic ucast_vlan_discard,
  output logic mcast_storm_excluded,
  output logic backpressure_carrier,
  output logic fair_mode,
  output logic no_collision_drop
);

  typedef enum logic [1:0] {SGFC_ST_STRAP, SGFC_ST_RUN} sgfc_state_t;

  sgfc_state_t state_q, state_d;
  logic [7:0] limits_q, limits_d;
  logic [7:0] features_q, features_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [10:0] len_tag_q, len_tag_d;
  logic [10:0] len_untag_q, len_untag_d;
  logic [6:0] resv_q, resv_d;
  logic [3:0] ratio_q, ratio_d;
  logic strict_q, strict_d;

  // The reserve count must fit the seven-bit output
  if (RESERVE_BUFFERS < 1 || RESERVE_BUFFERS > 127) begin : g_bad_reserve
    $error("RESERVE_BUFFERS must lie in 1..127");
  end

  // Read mux shared by the read path; unmapped offsets read zero
  function automatic logic [7:0] sgfc_read(input logic [7:0] addr,
                                           input logic [7:0] lim,
                                           input logic [7:0] feat);
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      SGFC_OFS_LIMITS: val = lim;
      SGFC_OFS_FEATURES: val = feat;
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  // Register state: strap capture one cycle after reset, then host writes
  always_comb begin
    state_d = state_q;
    limits_d = limits_q;
    features_d = features_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    case (state_q)
      SGFC_ST_STRAP: begin
        // Straps are sampled after release, never under reset itself
        limits_d[SGFC_BIT_SIZE_CHECK_OFF] = size_limit_strap_pin;
        limits_d[SGFC_BIT_NO_COLL_DROP] = collision_strap_pin;
        state_d = SGFC_ST_RUN;
      end
      SGFC_ST_RUN: begin
        // Writes take effect next cycle with no reset needed
        if (reg_write && reg_addr == SGFC_OFS_LIMITS) begin
          limits_d = reg_write_data;
        end
        if (reg_write && reg_addr == SGFC_OFS_FEATURES) begin
          features_d = reg_write_data;
        end
      end
      default: state_d = SGFC_ST_RUN;
    endcase
    if (reg_read) begin
      rdata_d = sgfc_read(reg_addr, limits_q, features_q);
      rvalid_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= SGFC_ST_STRAP;
      limits_q <= SGFC_RST_LIMITS;
      features_q <= SGFC_RST_FEATURES;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      limits_q <= limits_d;
      features_q <= features_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Derived policy values; huge setting wins over the size check bit
  always_comb begin
    if (limits_d[SGFC_BIT_HUGE]) begin
      len_tag_d = SGFC_LEN_HUGE;
      len_untag_d = SGFC_LEN_HUGE;
    end else if (limits_d[SGFC_BIT_SIZE_CHECK_OFF]) begin
      len_tag_d = SGFC_LEN_LEGACY;
      len_untag_d = SGFC_LEN_LEGACY;
    end else begin
      len_tag_d = SGFC_LEN_TAGGED;
      len_untag_d = SGFC_LEN_UNTAGGED;
    end
    resv_d = limits_d[SGFC_BIT_PRIO_RESERVE] ? 7'(RESERVE_BUFFERS) : 7'h00;
    strict_d = (features_d[SGFC_BIT_SCHED_HI:SGFC_BIT_SCHED_LO] == 2'b00);
    case (features_d[SGFC_BIT_SCHED_HI:SGFC_BIT_SCHED_LO])
      2'b01: ratio_d = SGFC_RATIO_10;
      2'b10: ratio_d = SGFC_RATIO_5;
      2'b11: ratio_d = SGFC_RATIO_2;
      default: ratio_d = SGFC_RATIO_STRICT;
    endcase
  end

  // Registered so each derived output comes from a flip-flop, same cycle as the fields
  always_ff @(posedge clock) begin
    if (reset) begin
      len_tag_q <= SGFC_LEN_TAGGED;
      len_untag_q <= SGFC_LEN_UNTAGGED;
      resv_q <= 7'h00;
      ratio_q <= SGFC_RATIO_STRICT;
      strict_q <= 1'b1;
    end else begin
      len_tag_q <= len_tag_d;
      len_untag_q <= len_untag_d;
      resv_q <= resv_d;
      ratio_q <= ratio_d;
      strict_q <= strict_d;
    end
  end

  // Output fields straight from the register flops
  assign reg_read_data = rdata_q;
  assign reg_read_valid = rvalid_q;
  assign max_len_tagged = len_tag_q;
  assign max_len_untagged = len_untag_q;
  // Special-tagged CPU frames are never counted as tagged, in every mode
  assign cpu_special_tag_id_exempt_from_tag_limit = 1'b1;
  assign reserved_hi_buffers = resv_q;
  assign tag_vlan_enable = features_q[SGFC_BIT_TAG_VLAN];
  assign igmp_to_mii_enable = features_q[SGFC_BIT_IGMP_SNOOP];
  assign mii_direct_enable = features_q[SGFC_BIT_DIRECT];
  assign mii_pretag_enable = features_q[SGFC_BIT_PRETAG];
  assign sched_strict = strict_q;
  assign sched_ratio = ratio_q;
  assign vid_port_mask_enable = features_q[SGFC_BIT_TAG_MASK];
  // One flag carries both sniff modes: 1 = AND match, 0 = OR match
  assign sniff_match_both = features_q[SGFC_BIT_SNIFF_AND];
  assign ucast_vlan_discard = limits_q[SGFC_BIT_UCAST_VLAN_DISCARD];
  assign mcast_storm_excluded = limits_q[SGFC_BIT_MCAST_STORM_OFF];
  assign backpressure_carrier = limits_q[SGFC_BIT_BACKPRESSURE_MODE];
  assign fair_mode = limits_q[SGFC_BIT_FAIR_MODE];
  assign no_collision_drop = limits_q[SGFC_BIT_NO_COLL_DROP];

endmodule // sgfc_switch_global_forwarding_control

// file: verif/sgfc_host.sv
`timescale 1ns/1ps
module sgfc_host (
  input wire logic clock, reg_read_valid,
  input wire logic [7:0] reg_read_data,
  output logic reg_write = 1'b0, reg_read = 1'b0,
  output logic [7:0] reg_addr = 8'h00, reg_write_data = 8'h00
);
  // One-cycle strobe; idle data inverted so a stale byte never looks fresh
  task automatic wr(input logic [7:0] a, d);
    @(negedge clock);
    reg_addr = a;
    reg_write_data = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    reg_write_data = ~d;
  endtask
  // Data is taken in the single cycle that valid stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    d = reg_read_valid ? reg_read_data : 8'hxx;
  endtask
endmodule // sgfc_host

// file: verif/sgfc_sva.sv
`timescale 1ns/1ps
module sgfc_sva
  import sgfc_pkg::*;
(
  input wire logic clock, reset, size_limit_strap_pin, reg_write, reg_read, reg_read_valid,
  input wire logic tag_vlan_enable, sched_strict, sniff_match_both,
  input wire logic [7:0] reg_addr, reg_write_data,
  input wire logic [10:0] max_len_tagged, max_len_untagged,
  input wire logic [6:0] reserved_hi_buffers,
  input wire logic [3:0] sched_ratio
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Skip strobes in the strap cycles just after release
  logic [1:0] up_q;
  always_ff @(posedge clock) up_q <= {up_q[0], ~reset};
  wire lw = up_q[1] && reg_write && reg_addr == SGFC_OFS_LIMITS;
  wire fw = up_q[1] && reg_write && reg_addr == SGFC_OFS_FEATURES;
  function automatic logic [3:0] rt(input logic [1:0] s);
    return s == 2'h0 ? 4'h0 : s == 2'h1 ? 4'hA : s == 2'h2 ? 4'h5 : 4'h2;
  endfunction
  read_valid_a: assert property (reg_read |=> reg_read_valid) else $error("no read valid");
  strap_load_a: assert property (
    $fell(reset) |-> ##[1:2] max_len_tagged == (size_limit_strap_pin ? 11'h600 : 11'h5F2))
    else $error("strap not loaded");
  huge_len_a: assert property (
    lw && reg_write_data[2] |=> max_len_untagged == 11'h77C && max_len_tagged == 11'h77C)
    else $error("huge limit");
  size_sel_a: assert property (
    lw && !reg_write_data[2] |=>
    max_len_untagged == ($past(reg_write_data[1]) ? 11'h600 : 11'h5EE)) else $error("size limit");
  reserve_a: assert property (
    lw |=> reserved_hi_buffers == ($past(reg_write_data[0]) ? 7'h30 : 7'h00)) else $error("reserve");
  feat_bits_a: assert property (
    fw |=> tag_vlan_enable == $past(reg_write_data[7]) && sniff_match_both == $past(reg_write_data[0]))
    else $error("feature bits");
  sched_ratio_a: assert property (
    fw |=> sched_ratio == rt($past(reg_write_data[3:2]))) else $error("ratio");
  strict_flag_a: assert property (
    fw |=> sched_strict == ($past(reg_write_data[3:2]) == 2'h0)) else $error("strict flag");
endmodule // sgfc_sva
bind sgfc_switch_global_forwarding_control sgfc_sva chk (.*);

// file: verif/tb.sv
`timescale 1ns/1ps
module tb
  import sgfc_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic size_limit_strap_pin = 1'b1;
  logic collision_strap_pin = 1'b0;
  logic reg_write, reg_read, reg_read_valid, cpu_special_tag_id_exempt_from_tag_limit, tag_vlan_enable;
  logic igmp_to_mii_enable, mii_direct_enable, mii_pretag_enable, sched_strict;
  logic vid_port_mask_enable, sniff_match_both;
  logic ucast_vlan_discard, mcast_storm_excluded, backpressure_carrier, fair_mode;
  logic no_collision_drop;
  logic [7:0] reg_addr, reg_write_data, reg_read_data, v;
  logic [10:0] max_len_tagged, max_len_untagged;
  logic [6:0] reserved_hi_buffers;
  logic [3:0] sched_ratio;
  logic [3:0] ratio [4] = '{4'h0, 4'hA, 4'h5, 4'h2};
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  sgfc_switch_global_forwarding_control dut (.*);
  sgfc_host host (.*);
  initial forever #5 clock = ~clock;
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard, well past the fewer than fifty cycles the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(negedge clock);
    reset = 1'b0;
    repeat (3) @(negedge clock);
    host.rd(SGFC_OFS_LIMITS, v);
    chk(v, 8'hF2);
    chk({ucast_vlan_discard, mcast_storm_excluded, backpressure_carrier, fair_mode,
      no_collision_drop}, 5'h1E);
    chk({max_len_tagged, cpu_special_tag_id_exempt_from_tag_limit}, {11'h600, 1'b1});
    host.wr(SGFC_OFS_LIMITS, 8'h01);
    chk({max_len_tagged, max_len_untagged, reserved_hi_buffers}, {11'h5F2, 11'h5EE, 7'h30});
    host.wr(SGFC_OFS_LIMITS, 8'h06);
    chk({max_len_tagged, max_len_untagged, reserved_hi_buffers}, {11'h77C, 11'h77C, 7'h0});
    // Unmapped place reads zero and leaves the limits alone
    host.wr(8'h06, 8'hFF);
    host.rd(8'h06, v);
    chk(v, 8'h00);
    host.rd(SGFC_OFS_LIMITS, v);
    chk(v, 8'h06);
    chk({ucast_vlan_discard, mcast_storm_excluded, backpressure_carrier, fair_mode,
      no_collision_drop}, 5'h00);
    for (int s = 0; s < 4; s++) begin
      host.wr(SGFC_OFS_FEATURES, {4'hD, s[1:0], s[0], ~s[0]});
      host.rd(SGFC_OFS_FEATURES, v);
      chk(v, {4'hD, s[1:0], s[0], ~s[0]});
      chk({tag_vlan_enable, igmp_to_mii_enable, mii_direct_enable, mii_pretag_enable,
        vid_port_mask_enable, sniff_match_both}, {4'hD, s[0], ~s[0]});
      chk({sched_strict, sched_ratio}, {s == 0, ratio[s]});
    end
    stop_test();
  end
endmodule // tb
